// [shared/sfb_pkg.sv]
package sfb_pkg;
  localparam int ADDR_W = 13;
  localparam int IADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int ROW_LSB = 7;
  localparam int COL32_W = 7;
  localparam int COL16_W = 8;
  localparam int MODE_W = 8;
  // Mode register field layout
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BT_BIT = 2;
  localparam int MODE_CL_LSB = 3;
  localparam int MODE_RL_BIT = 6;
  localparam int MODE_ID_BIT = 7;
  localparam logic [1:0] BL_FOUR = 2'h1;
  localparam logic [1:0] BL_EIGHT = 2'h2;
  localparam logic [1:0] BL_BOOT = 2'h3;
  localparam logic [2:0] BEAT4_MASK = 3'h3;
  localparam logic [2:0] BEAT8_MASK = 3'h7;
  localparam logic [2:0] BEAT4_LAST = 3'h3;
  localparam logic [2:0] BEAT8_LAST = 3'h7;
  // Default: array read, row latency 2, column latency 5, length 4, sequential
  localparam logic [MODE_W-1:0] MODE_RESET = 8'h61;
  // Column latency code n gives latency n+1
  localparam logic [3:0] CL_OFFSET = 4'h1;
  localparam logic [3:0] CL_ONE = 4'h1;
  localparam logic [3:0] CL_ZERO = 4'h0;
  localparam logic [2:0] BEAT_ZERO = 3'h0;
  localparam logic [2:0] BEAT_ONE = 3'h1;

  // Command strobes sampled together
  typedef struct packed {
    logic chip_select_n;
    logic row_strobe_n;
    logic column_strobe_n;
    logic mode_reg_strobe_n;
  } sfb_cmd_t;

  typedef enum logic [1:0] {
    SFB_IDLE_CMD,
    SFB_ACTIVATE,
    SFB_READ,
    SFB_MODE_LOAD_CMD
  } sfb_op_t;
endpackage : sfb_pkg

// [core/sfb_front_end.sv]
`timescale 1ns/1ps
`default_nettype none

// Contract
// - x32: row from pins 0-12, column from pins 0-6, rest ignored.
// - x16: row from pins 0-12, column from pins 0-7, rest ignored.
// - x32 internal address: row in bits 19:7, column in bits 6:0.
// - x16: column bit 0 low gives low half, high gives upper half.
// - Boot block mode runs 16 wide, address straight from pins 0-12.
// - Burst of four: sequential modulo four, interleaved start XOR beat.
// - Burst of eight: sequential modulo eight, interleaved start XOR beat.
// - Everything sampled and advanced on the rising clock edge only.
// - Clock gate low suspends internal clock; outputs and burst address freeze, except array_rd, which goes low.
// - While clock gate stays low, all other inputs except organization select are ignored.
// - Clock gate high again: commands accepted from the edge after that one.
// - Select low with all strobes high is an idle command.
// - Select high disables decoding; strobes and address ignored.
// - Data outputs stay high impedance after recommended power-up.
// - Auto-boot variant enters boot block mode right after power-up.
// - Organization select high is x32, low is x16.
// - Address arrives as row activation then column command.
// - Mode bits 1:0 burst length, bit 2 burst type.
// - Mode register resets to array read, latencies 2 and 5, length 4, sequential.
// - First data column-latency cycles after read, then consecutive beats.
module sfb_front_end #(
  parameter bit AUTO_BOOT = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clock_gate_in,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic mode_reg_strobe_n,
  input wire logic org_select_n,
  input wire logic [sfb_pkg::ADDR_W-1:0] addr_in,
  input wire logic [sfb_pkg::DATA_W-1:0] array_data,
  output logic [sfb_pkg::IADDR_W-1:0] internal_addr_bit,
  output logic array_rd,
  output logic [sfb_pkg::DATA_W-1:0] dq_out,
  output logic [sfb_pkg::DATA_W-1:0] dq_oe,
  output logic boot_mode,
  output logic [sfb_pkg::MODE_W-1:0] mode_reg
);

  // Two-stage synchronisers for pin inputs
  logic [sfb_pkg::ADDR_W+5:0] pin_s1;
  logic [sfb_pkg::ADDR_W+5:0] pin_s2;

  always_ff @(posedge mclk) begin
    pin_s1 <= {clock_gate_in, chip_select_n, row_strobe_n, column_strobe_n, mode_reg_strobe_n, org_select_n, addr_in};
    pin_s2 <= pin_s1;
  end

  logic cke_s;
  sfb_pkg::sfb_cmd_t cmd_s;
  logic org_s;
  logic [sfb_pkg::ADDR_W-1:0] addr_s;
  assign {cke_s, cmd_s, org_s, addr_s} = pin_s2;

  // Clock gate sampled low suspends from the next cycle on
  logic run;
  logic next_run;
  assign next_run = cke_s;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      run <= 1'b1;
    end else begin
      run <= next_run;
    end
  end

  // Command decode; deselect and all-high strobes both fall to idle
  function automatic sfb_pkg::sfb_op_t decode(input sfb_pkg::sfb_cmd_t c);
    if (c.chip_select_n) begin
      return sfb_pkg::SFB_IDLE_CMD;
    end else if (!c.row_strobe_n && !c.column_strobe_n && !c.mode_reg_strobe_n) begin
      return sfb_pkg::SFB_MODE_LOAD_CMD;
    end else if (!c.row_strobe_n && c.column_strobe_n && c.mode_reg_strobe_n) begin
      return sfb_pkg::SFB_ACTIVATE;
    end else if (c.row_strobe_n && !c.column_strobe_n && c.mode_reg_strobe_n) begin
      return sfb_pkg::SFB_READ;
    end else begin
      return sfb_pkg::SFB_IDLE_CMD;
    end
  endfunction : decode

  sfb_pkg::sfb_op_t op;
  assign op = (run && cke_s) ? decode(cmd_s) : sfb_pkg::SFB_IDLE_CMD;

  // Burst ordering for one beat
  function automatic logic [2:0] beat_addr(input logic [2:0] start, input logic [2:0] beat,
                                           input logic interleave, input logic [2:0] mask);
    logic [2:0] seq;
    seq = start + beat;
    if (interleave) begin
      return (start & ~mask) | ((start ^ beat) & mask);
    end
    return (start & ~mask) | (seq & mask);
  endfunction : beat_addr

  // Front-end state
  logic [sfb_pkg::ADDR_W-1:0] row_addr;
  logic [sfb_pkg::COL16_W-1:0] col_addr;
  logic [2:0] beat;
  logic [3:0] lat_cnt;
  logic bursting;
  logic data_phase;
  logic org32;
  logic [sfb_pkg::ADDR_W-1:0] next_row_addr;
  logic [sfb_pkg::COL16_W-1:0] next_col_addr;
  logic [2:0] next_beat;
  logic [3:0] next_lat_cnt;
  logic next_bursting;
  logic next_data_phase;
  logic [sfb_pkg::MODE_W-1:0] next_mode_reg;
  logic next_boot_mode;
  logic [sfb_pkg::IADDR_W-1:0] next_internal_addr_bit;
  logic next_array_rd;
  logic [sfb_pkg::DATA_W-1:0] next_dq_out;
  logic [sfb_pkg::DATA_W-1:0] next_dq_oe;
  logic next_org32;

  logic [2:0] mask;
  logic [2:0] last;
  logic [3:0] cl_cycles;
  logic [2:0] ba;
  logic [sfb_pkg::COL16_W-1:0] cur_col;
  logic half_sel;
  logic [2:0] idx;
  logic [2:0] dba;

  always_comb begin
    mask = (mode_reg[sfb_pkg::MODE_BL_LSB +: 2] == sfb_pkg::BL_EIGHT) ? sfb_pkg::BEAT8_MASK
                                                                      : sfb_pkg::BEAT4_MASK;
    last = (mode_reg[sfb_pkg::MODE_BL_LSB +: 2] == sfb_pkg::BL_EIGHT) ? sfb_pkg::BEAT8_LAST
                                                                      : sfb_pkg::BEAT4_LAST;
    cl_cycles = {1'b0, mode_reg[sfb_pkg::MODE_CL_LSB +: 3]} + sfb_pkg::CL_OFFSET;
    // Address runs one beat ahead of the data it fetches, so it uses the next index
    idx = data_phase ? beat + sfb_pkg::BEAT_ONE : beat;
    ba = beat_addr(col_addr[2:0], idx, mode_reg[sfb_pkg::MODE_BT_BIT], mask);
    cur_col = {col_addr[sfb_pkg::COL16_W-1:3], ba};
    // Half select follows the beat whose word is returning now
    dba = beat_addr(col_addr[2:0], beat, mode_reg[sfb_pkg::MODE_BT_BIT], mask);
    half_sel = dba[0];
  end

  // Next-state logic; when suspended everything holds except array_rd, which clears, and org32, which tracks the pin
  always_comb begin
    next_row_addr = row_addr;
    next_col_addr = col_addr;
    next_beat = beat;
    next_lat_cnt = lat_cnt;
    next_bursting = bursting;
    next_data_phase = data_phase;
    next_mode_reg = mode_reg;
    next_boot_mode = boot_mode;
    next_internal_addr_bit = internal_addr_bit;
    next_array_rd = 1'b0;
    next_dq_out = dq_out;
    next_dq_oe = dq_oe;
    next_org32 = org_s;
    if (run) begin
      // Burst progress
      if (bursting) begin
        if (lat_cnt > sfb_pkg::CL_ONE) begin
          next_lat_cnt = lat_cnt - sfb_pkg::CL_ONE;
        end else begin
          next_data_phase = 1'b1;
        end
      end
      // Address presented to the array one cycle ahead of data
      if (bursting && (data_phase ? (beat != last) : (lat_cnt <= sfb_pkg::CL_ONE))) begin
        if (boot_mode) begin
          next_internal_addr_bit = {{(sfb_pkg::IADDR_W-sfb_pkg::ADDR_W){1'b0}}, addr_s};
        end else if (org32) begin
          next_internal_addr_bit = {row_addr, cur_col[sfb_pkg::COL32_W-1:0]};
        end else begin
          next_internal_addr_bit = {row_addr, cur_col[sfb_pkg::COL16_W-1:1]};
        end
        next_array_rd = 1'b1;
      end
      // Data drive from returned array word
      if (data_phase) begin
        if (org32 && !boot_mode) begin
          next_dq_out = array_data;
          next_dq_oe = '1;
        end else begin
          next_dq_out = {{sfb_pkg::HALF_W{1'b0}},
                         half_sel ? array_data[sfb_pkg::DATA_W-1:sfb_pkg::HALF_W]
                                  : array_data[sfb_pkg::HALF_W-1:0]};
          next_dq_oe = {{sfb_pkg::HALF_W{1'b0}}, {sfb_pkg::HALF_W{1'b1}}};
        end
        if (beat == last) begin
          next_bursting = 1'b0;
          next_data_phase = 1'b0;
          next_beat = sfb_pkg::BEAT_ZERO;
        end else begin
          next_beat = beat + sfb_pkg::BEAT_ONE;
        end
      end else begin
        next_dq_oe = '0;
      end
      // New command; a new read restarts the burst
      case (op)
        sfb_pkg::SFB_ACTIVATE: begin
          next_row_addr = addr_s;
        end
        sfb_pkg::SFB_READ: begin
          next_col_addr = org_s ? {1'b0, addr_s[sfb_pkg::COL32_W-1:0]}
                                : addr_s[sfb_pkg::COL16_W-1:0];
          next_beat = sfb_pkg::BEAT_ZERO;
          next_lat_cnt = cl_cycles;
          next_bursting = 1'b1;
          next_data_phase = 1'b0;
        end
        sfb_pkg::SFB_MODE_LOAD_CMD: begin
          next_mode_reg = addr_s[sfb_pkg::MODE_W-1:0];
          next_boot_mode = (addr_s[sfb_pkg::MODE_BL_LSB +: 2] == sfb_pkg::BL_BOOT);
        end
        default: begin
        end
      endcase
    end
  end

  // Registers; reset gives default mode and tri-stated data
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      row_addr <= '0;
      col_addr <= '0;
      beat <= sfb_pkg::BEAT_ZERO;
      lat_cnt <= sfb_pkg::CL_ZERO;
      bursting <= 1'b0;
      data_phase <= 1'b0;
      mode_reg <= sfb_pkg::MODE_RESET;
      boot_mode <= AUTO_BOOT;
      internal_addr_bit <= '0;
      array_rd <= 1'b0;
      dq_out <= '0;
      dq_oe <= '0;
      org32 <= 1'b1;
    end else begin
      row_addr <= next_row_addr;
      col_addr <= next_col_addr;
      beat <= next_beat;
      lat_cnt <= next_lat_cnt;
      bursting <= next_bursting;
      data_phase <= next_data_phase;
      mode_reg <= next_mode_reg;
      boot_mode <= next_boot_mode;
      internal_addr_bit <= next_internal_addr_bit;
      array_rd <= next_array_rd;
      dq_out <= next_dq_out;
      dq_oe <= next_dq_oe;
      org32 <= next_org32;
    end
  end

endmodule : sfb_front_end

`default_nettype wire

// [dv/sfb_array_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Array stand-in; bit 15 of each half says which half it came from
module sfb_array_model (
  input wire logic [19:0] addr,
  output logic [31:0] data
);
  // A swapped half shows at once in x16 reads
  assign data = {1'b1, addr[14:0], 1'b0, addr[14:0]};
endmodule : sfb_array_model
`default_nettype wire

// [dv/sfb_front_end_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module sfb_front_end_sva #(parameter bit AUTO_BOOT = 1'b0) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clock_gate_in,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic mode_reg_strobe_n,
  input wire logic org_select_n,
  input wire logic [19:0] internal_addr_bit,
  input wire logic array_rd,
  input wire logic [31:0] dq_out,
  input wire logic [31:0] dq_oe,
  input wire logic boot_mode,
  input wire logic [7:0] mode_reg
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Runs are long enough to flush the pin sync flops
  sequence gate_low_s; !clock_gate_in [*6]; endsequence
  sequence desel_s; chip_select_n [*5]; endsequence
  sequence idle_s; (!chip_select_n && row_strobe_n && column_strobe_n && mode_reg_strobe_n) [*5]; endsequence
  reset_state_a:
  assert property (disable iff (1'b0) !rst_n |=> dq_oe == 32'h0 && !array_rd
    && mode_reg == sfb_pkg::MODE_RESET && boot_mode == AUTO_BOOT) else $error("bad reset state");
  gate_freeze_a:
  assert property (gate_low_s |=> $stable(internal_addr_bit) && $stable(dq_out) && $stable(mode_reg))
    else $error("state moved while gated");
  oe_shape_a:
  assert property (dq_oe inside {32'h0, 32'h0000ffff, 32'hffffffff}) else $error("odd enable");
  half_only_a:
  assert property (!org_select_n [*4] |-> dq_oe[31:16] == 16'h0) else $error("x16 drives top");
  boot_code_a:
  assert property (boot_mode && !AUTO_BOOT |-> mode_reg[1:0] == sfb_pkg::BL_BOOT) else $error("boot w/o code");
  deselect_a:
  assert property (desel_s |=> $stable(mode_reg)) else $error("deselect decoded");
  idle_a:
  assert property (idle_s |=> $stable(mode_reg)) else $error("idle changed mode");
  burst_row_a:
  assert property (array_rd && $past(array_rd) |-> internal_addr_bit[19:3] == $past(internal_addr_bit[19:3]))
    else $error("burst left its block");
  beats_run_a:
  assert property ($fell(dq_oe[0]) |-> $past(dq_oe[0], 4)) else $error("burst too short");
endmodule : sfb_front_end_sva
`default_nettype wire

// [dv/sfb_front_end_test.sv]
`timescale 1ns/1ps
`default_nettype none
module sfb_front_end_test;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic gate = 1'b1;
  logic org = 1'b1;
  logic [12:0] addr = 13'h0;
  sfb_pkg::sfb_cmd_t cmd = 4'hf;
  logic [31:0] adata, dq, oe;
  logic [19:0] ia;
  logic rd, boot;
  logic [7:0] mode;
  int n_fail = 0;
  int checked = 0;
  // 200 MHz
  always #2.5 mclk = ~mclk;
  sfb_front_end u_sfb_front_end (.mclk(mclk), .rst_n(rst_n), .clock_gate_in(gate),
    .chip_select_n(cmd.chip_select_n), .row_strobe_n(cmd.row_strobe_n),
    .column_strobe_n(cmd.column_strobe_n), .mode_reg_strobe_n(cmd.mode_reg_strobe_n),
    .org_select_n(org), .addr_in(addr), .array_data(adata), .internal_addr_bit(ia),
    .array_rd(rd), .dq_out(dq), .dq_oe(oe), .boot_mode(boot), .mode_reg(mode));
  sfb_array_model u_sfb_array_model (.addr(ia), .data(adata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  // One command cycle; pins then go idle and the address flips so nothing stale lingers
  task automatic issue(input logic [3:0] c, input logic [12:0] a);
    @(posedge mclk);
    cmd <= c;
    addr <= a;
    @(posedge mclk);
    cmd <= 4'hf;
    addr <= ~a;
  endtask : issue
  task automatic load(input logic [7:0] m);
    issue(4'h0, {5'h0, m});
    // Six settle cycles plus pin sync
    tick(8);
    chk({24'h0, mode}, {24'h0, m});
  endtask : load
  function automatic logic [7:0] beat(input logic [7:0] s, input logic [7:0] j, input logic [7:0] m);
    logic [7:0] mk;
    mk = m[1] ? 8'h7 : 8'h3;
    return m[2] ? s ^ j : (s & ~mk) | ((s + j) & mk);
  endfunction : beat
  // Row then column; pins above the column carry junk
  task automatic burst(input logic [12:0] row, input logic [7:0] col, input logic [7:0] m);
    int na, nd;
    logic [7:0] c;
    na = 0;
    nd = 0;
    issue(4'h3, row);
    tick(3);
    issue(4'h5, {5'h1f, col});
    repeat (40) begin
      @(posedge mclk);
      #1;
      if (rd === 1'b1) begin
        c = beat(col, na[7:0], m);
        if (org) chk({12'h0, ia}, {12'h0, row, c[6:0]});
        else chk({12'h0, ia}, {12'h0, row, c[7:1]});
        na++;
      end
      if (oe[0] === 1'b1) begin
        c = beat(col, nd[7:0], m);
        if (org) chk(dq, {1'b1, row[7:0], c[6:0], 1'b0, row[7:0], c[6:0]});
        else chk(dq, {16'h0, c[0], row[7:0], c[7:1]});
        chk(oe, org ? 32'hffffffff : 32'h0000ffff);
        nd++;
      end
    end
    chk(32'(na), m[1] ? 32'h8 : 32'h4);
    chk(32'(nd), m[1] ? 32'h8 : 32'h4);
  endtask : burst
  // Length-8 sequential burst with the clock gate dropped mid-data; beats must resume in order
  task automatic frozen_burst;
    int nd;
    logic [31:0] prev;
    logic [7:0] c;
    nd = 0;
    prev = '0;
    issue(4'h3, 13'h0777);
    tick(3);
    issue(4'h5, {5'h1f, 8'h42});
    for (int k = 0; k < 40; k++) begin
      @(posedge mclk);
      gate <= (k < 9 || k >= 15);
      #1;
      if (oe[0] === 1'b1 && dq !== prev) begin
        c = beat(8'h42, nd[7:0], 8'h62);
        chk(dq, {1'b1, 8'h77, c[6:0], 1'b0, 8'h77, c[6:0]});
        nd++;
      end
      prev = oe[0] ? dq : '0;
    end
    chk(32'(nd), 32'h8);
  endtask : frozen_burst
  task automatic do_reset(input logic o);
    @(posedge mclk);
    rst_n <= 1'b0;
    org <= o;
    tick(6);
    rst_n <= 1'b1;
    tick(1);
    chk({24'h0, mode}, {24'h0, sfb_pkg::MODE_RESET});
    chk(oe, 32'h0);
    chk({31'h0, boot}, 32'h0);
  endtask : do_reset
  // Gated load is dropped; load right after ungating is taken
  task automatic gate_hold;
    @(posedge mclk);
    gate <= 1'b0;
    issue(4'h0, 13'h0062);
    tick(6);
    chk({24'h0, mode}, 32'h66);
    gate <= 1'b1;
    load(8'h65);
  endtask : gate_hold
  task automatic quiet;
    issue(4'h8, 13'h0062);
    tick(8);
    chk({24'h0, mode}, 32'h65);
    issue(4'h7, 13'h0062);
    tick(8);
    chk({24'h0, mode}, 32'h65);
  endtask : quiet
  initial begin
    tick(6);
    rst_n <= 1'b1;
    tick(1);
    burst(13'h1a5c, 8'hcd, sfb_pkg::MODE_RESET);
    load(8'h65);
    burst(13'h0f0f, 8'h8b, 8'h65);
    load(8'h62);
    burst(13'h1234, 8'hfd, 8'h62);
    frozen_burst();
    load(8'h66);
    burst(13'h0abc, 8'h86, 8'h66);
    gate_hold();
    quiet();
    load(8'h63);
    chk({31'h0, boot}, 32'h1);
    do_reset(1'b0);
    burst(13'h0155, 8'hfb, 8'h61);
    load(8'h66);
    burst(13'h1ccc, 8'h35, 8'h66);
    final_report();
  end
endmodule : sfb_front_end_test
bind sfb_front_end sfb_front_end_sva #(.AUTO_BOOT(AUTO_BOOT)) u_sfb_front_end_sva (.mclk(mclk),
  .rst_n(rst_n), .clock_gate_in(clock_gate_in), .chip_select_n(chip_select_n),
  .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n), .mode_reg_strobe_n(mode_reg_strobe_n),
  .org_select_n(org_select_n), .internal_addr_bit(internal_addr_bit), .array_rd(array_rd),
  .dq_out(dq_out), .dq_oe(dq_oe), .boot_mode(boot_mode), .mode_reg(mode_reg));
`default_nettype wire
